// ===== rtl/txpp_pkg.sv
// Constants and types for the preamble passthrough transmit mapper
package txpp_pkg;

  // ---------------------------------------------------------------
  // Control characters and preamble layout
  // ---------------------------------------------------------------
  localparam logic [7:0] TXPP_START_CHAR = 8'hFB;
  localparam int TXPP_PRE_W = 64;
  localparam int TXPP_PRE_TOP_LSB = 56;
  localparam int TXPP_SA_W = 48;
  localparam int TXPP_LT_W = 16;

  // ---------------------------------------------------------------
  // Field positions per bus width
  // ---------------------------------------------------------------
  localparam int TXPP_W512 = 512;
  localparam int TXPP_W128 = 128;
  localparam int TXPP_W64 = 64;
  localparam int TXPP_SA_LSB_512 = 352;
  localparam int TXPP_LT_LSB_512 = 336;
  localparam int TXPP_SA_LSB_128 = 32;
  localparam int TXPP_LT_LSB_128 = 16;
  localparam int TXPP_SA_HI_LSB_64 = 0;
  localparam int TXPP_SA_LO_LSB_64 = 32;
  localparam int TXPP_LT_LSB_64 = 16;

  // ---------------------------------------------------------------
  // Header word tracking for the narrow bus, reset values
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    TXPP_IDLE = 2'h0,
    TXPP_W1 = 2'h1,
    TXPP_W2 = 2'h3,
    TXPP_BODY = 2'h2
  } txpp_st_e;

  localparam txpp_st_e TXPP_ST_RST = TXPP_IDLE;

endpackage : txpp_pkg

// ===== rtl/txpp_ovl.sv
// Byte-field overlay: replaces masked bits of a word with new values
`timescale 1ns/100ps
`default_nettype none
module txpp_ovl #(
  parameter int DW = 512
) (
  input wire logic [DW-1:0] word_i,
  input wire logic [DW-1:0] val_i,
  input wire logic [DW-1:0] mask_i,
  output logic [DW-1:0] word_o
);
  import txpp_pkg::*;

  assign word_o = (word_i & ~mask_i) | (val_i & mask_i);

endmodule : txpp_ovl
`default_nettype wire

// ===== rtl/txpp_map.sv
// Transmit header mapper with custom preamble passthrough
//
// Operation
// - First preamble octet is always replaced by the start control char.
// - Wide bus: preamble, destination, source, length/type, payload.
// - Narrow bus: preamble word, DA plus SA top, SA low plus type.
// - Mid bus takes preamble on its own 64-bit input, top octet first.
// - Mid bus first word: DA, SA, length/type, first payload octets.
// - Source insertion overwrites source address unless raw flag high.
`timescale 1ns/100ps
`default_nettype none
module txpp_map #(
  parameter int DW = 512,
  parameter int EW = 6
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic tx_valid_i,
  input wire logic tx_sop_i,
  input wire logic tx_eop_i,
  input wire logic [EW-1:0] tx_empty_i,
  input wire logic [DW-1:0] tx_data_i,
  input wire logic [txpp_pkg::TXPP_PRE_W-1:0] tx_preamble_i,
  input wire logic tx_raw_i,
  input wire logic sa_ins_en_i,
  input wire logic [txpp_pkg::TXPP_SA_W-1:0] station_addr_i,
  output logic out_valid_o,
  output logic out_sop_o,
  output logic out_eop_o,
  output logic [EW-1:0] out_empty_o,
  output logic [DW-1:0] out_data_o,
  output logic [txpp_pkg::TXPP_PRE_W-1:0] out_preamble_o,
  output logic out_ctrl_o
);
  import txpp_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic vld;
    logic sop;
    logic eop;
    logic [EW-1:0] emp;
    logic [DW-1:0] dat;
    logic [TXPP_PRE_W-1:0] pre;
    logic ctl;
    txpp_st_e st;
  } txpp_state_s;

  txpp_state_s s_r;
  txpp_state_s s_nxt;
  logic [DW-1:0] ovl_val;
  logic [DW-1:0] ovl_mask;
  logic [DW-1:0] mapped;
  logic ins;

  assign ins = sa_ins_en_i & ~tx_raw_i;

  // ---------------------------------------------------------------
  // Field overlay per bus width
  // ---------------------------------------------------------------
  if (DW == TXPP_W512) begin : g_w512
    always_comb begin
      ovl_val = '0;
      ovl_mask = '0;
      if (tx_sop_i) begin
        ovl_val[DW-1 -: 8] = TXPP_START_CHAR;
        ovl_mask[DW-1 -: 8] = 8'hFF;
        if (ins) begin
          ovl_val[TXPP_SA_LSB_512 +: TXPP_SA_W] = station_addr_i;
          ovl_mask[TXPP_SA_LSB_512 +: TXPP_SA_W] = '1;
        end
      end
    end
  end else if (DW == TXPP_W128) begin : g_w128
    always_comb begin
      ovl_val = '0;
      ovl_mask = '0;
      if (tx_sop_i && ins) begin
        ovl_val[TXPP_SA_LSB_128 +: TXPP_SA_W] = station_addr_i;
        ovl_mask[TXPP_SA_LSB_128 +: TXPP_SA_W] = '1;
      end
    end
  end else begin : g_w64
    always_comb begin
      ovl_val = '0;
      ovl_mask = '0;
      if (tx_sop_i) begin
        ovl_val[DW-1 -: 8] = TXPP_START_CHAR;
        ovl_mask[DW-1 -: 8] = 8'hFF;
      end else if (s_r.st == TXPP_W1 && ins) begin
        ovl_val[TXPP_SA_HI_LSB_64 +: 16] = station_addr_i[47:32];
        ovl_mask[TXPP_SA_HI_LSB_64 +: 16] = '1;
      end else if (s_r.st == TXPP_W2 && ins) begin
        ovl_val[TXPP_SA_LO_LSB_64 +: 32] = station_addr_i[31:0];
        ovl_mask[TXPP_SA_LO_LSB_64 +: 32] = '1;
      end
    end
  end

  txpp_ovl #(
    .DW(DW)
  ) u_ovl (
    .word_i(tx_data_i),
    .val_i(ovl_val),
    .mask_i(ovl_mask),
    .word_o(mapped)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.vld = tx_valid_i;
    s_nxt.sop = tx_valid_i & tx_sop_i;
    s_nxt.eop = tx_valid_i & tx_eop_i;
    s_nxt.emp = tx_empty_i;
    s_nxt.dat = mapped;
    s_nxt.ctl = tx_valid_i & tx_sop_i & (DW != TXPP_W128);
    s_nxt.pre = tx_preamble_i;
    if (tx_sop_i) begin
      s_nxt.pre[TXPP_PRE_TOP_LSB +: 8] = TXPP_START_CHAR;
    end
    if (tx_valid_i) begin
      unique case (s_r.st)
        TXPP_IDLE: begin
          if (tx_sop_i && !tx_eop_i) begin
            s_nxt.st = TXPP_W1;
          end
        end
        TXPP_W1: begin
          s_nxt.st = tx_eop_i ? TXPP_IDLE : TXPP_W2;
        end
        TXPP_W2: begin
          s_nxt.st = tx_eop_i ? TXPP_IDLE : TXPP_BODY;
        end
        TXPP_BODY: begin
          if (tx_eop_i) begin
            s_nxt.st = TXPP_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_r <= '{vld: 1'b0, sop: 1'b0, eop: 1'b0, emp: '0, dat: '0,
               pre: '0, ctl: 1'b0, st: TXPP_ST_RST};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out_valid_o = s_r.vld;
  assign out_sop_o = s_r.sop;
  assign out_eop_o = s_r.eop;
  assign out_empty_o = s_r.emp;
  assign out_data_o = s_r.dat;
  assign out_preamble_o = s_r.pre;
  assign out_ctrl_o = s_r.ctl;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence hdr_start_q;
    tx_valid_i && tx_sop_i;
  endsequence

  sequence hdr_ins_q;
    hdr_start_q ##0 ins;
  endsequence

  pre_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hdr_start_q |=> out_preamble_o[55:0] == $past(tx_preamble_i[55:0]))
    else $error("preamble octets two to eight altered");

  pre_start_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hdr_start_q |=> out_preamble_o[63:56] == TXPP_START_CHAR && out_sop_o)
    else $error("preamble top octet not start char");

  lat_pass_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_valid_i && !tx_sop_i && s_r.st != TXPP_W1 && s_r.st != TXPP_W2
    |=> out_valid_o && out_data_o == $past(tx_data_i))
    else $error("body word not passed unchanged");

  raw_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    hdr_start_q ##0 tx_raw_i
    |=> out_data_o[DW-9:0] == $past(tx_data_i[DW-9:0]))
    else $error("raw frame header modified");

  if (DW == TXPP_W512) begin : g_a512
    sop_char_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hdr_start_q |=> out_data_o[511:504] == TXPP_START_CHAR && out_ctrl_o)
      else $error("start char missing on wide bus");
    sa_ins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hdr_ins_q |=> out_data_o[399:352] == $past(station_addr_i)
        && out_data_o[351:0] == $past(tx_data_i[351:0]))
      else $error("wide bus source insertion wrong");
  end else if (DW == TXPP_W128) begin : g_a128
    sa_ins_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hdr_ins_q |=> out_data_o[79:32] == $past(station_addr_i)
        && out_data_o[127:80] == $past(tx_data_i[127:80]))
      else $error("mid bus source insertion wrong");
    no_ctrl_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hdr_start_q |=> !out_ctrl_o && out_data_o[127:120] ==
        $past(tx_data_i[127:120]))
      else $error("mid bus data word altered at top");
  end else begin : g_a64
    sequence hdr3_q;
      hdr_start_q ##0 ins && !tx_eop_i ##1 tx_valid_i && ins && !tx_eop_i
        ##1 tx_valid_i && ins;
    endsequence
    sop_char_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hdr_start_q |=> out_data_o[63:56] == TXPP_START_CHAR && out_ctrl_o)
      else $error("start char missing on narrow bus");
    sa_split_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      hdr3_q |-> ##1 out_data_o[63:32] == $past(station_addr_i[31:0])
        && $past(out_data_o[15:0]) == $past(station_addr_i[47:32], 2)
        && out_data_o[31:0] == $past(tx_data_i[31:0]))
      else $error("narrow bus source split wrong");
  end

endmodule : txpp_map
`default_nettype wire

// ===== tb/txpp_client.sv
// Client model feeding frames to the transmit mapper
`timescale 1ns/100ps
`default_nettype none
module txpp_client (
  input wire logic clk_i,
  output logic tx_valid_o,
  output logic tx_sop_o,
  output logic tx_eop_o,
  output logic [2:0] tx_empty_o,
  output logic [63:0] tx_data_o,
  output logic [63:0] tx_preamble_o,
  output logic tx_raw_o
);
  logic [31:0] seed_r = 32'h7F4E;

  function logic [63:0] rnd();
    for (int i = 0; i < 64; i++) begin
      seed_r = {seed_r[30:0], seed_r[31] ^ seed_r[21] ^ seed_r[1] ^ seed_r[0]};
      rnd[i] = seed_r[0];
    end
  endfunction : rnd

  // Released bus shows inverted data, never the last word
  task drive_idle();
    tx_valid_o = 1'b0;
    tx_sop_o = 1'b0;
    tx_eop_o = 1'b0;
    tx_data_o = ~tx_data_o;
    tx_preamble_o = ~tx_preamble_o;
  endtask : drive_idle

  task idle();
    @(negedge clk_i);
    drive_idle();
  endtask : idle

  task frame(input int len, input logic raw, input logic std);
    logic [63:0] pre;
    logic [63:0] r;
    r = rnd();
    pre = std ? {r[63:56], 56'h55_5555_5555_55D5} : r;
    for (int i = 0; i < len; i++) begin
      @(negedge clk_i);
      r = rnd();
      tx_valid_o = 1'b1;
      tx_sop_o = (i == 0);
      tx_eop_o = (i == len - 1);
      tx_raw_o = raw;
      tx_empty_o = r[2:0];
      tx_data_o = (i == 0) ? pre : r;
      tx_preamble_o = pre;
    end
  endtask : frame

  initial begin
    tx_data_o = 64'h0;
    tx_preamble_o = 64'h0;
    tx_empty_o = 3'h0;
    tx_raw_o = 1'b0;
    drive_idle();
  end
endmodule : txpp_client
`default_nettype wire

// ===== tb/txpp_map_tb.sv
// Self-checking bench for the transmit header mapper, all three bus widths
`timescale 1ns/100ps
`default_nettype none
module txpp_map_tb;
  import txpp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sa_ins_en_i = 1'b0;
  logic [47:0] station_addr_i = 48'h0;
  logic tx_valid_i, tx_sop_i, tx_eop_i, tx_raw_i;
  logic out_valid_o, out_sop_o, out_eop_o, out_ctrl_o;
  logic e_vld, e_sop, e_eop;
  logic [2:0] tx_empty_i, out_empty_o, e_empty;
  logic [63:0] tx_data_i, tx_preamble_i, out_data_o, out_preamble_o;
  logic [63:0] e_data, e_pre, r;
  logic vld_m, sop_m, eop_m, ctl_m, vld_w, sop_w, eop_w, ctl_w;
  logic [3:0] out_empty_m;
  logic [5:0] out_empty_w;
  logic [63:0] out_pre_m, out_pre_w;
  logic [127:0] d_m, out_data_m, e_data_m;
  logic [511:0] d_w, out_data_w, e_data_w;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int w, idx;

  always #12.5 clk_i = ~clk_i;

  txpp_map #(.DW(64), .EW(3)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_i),
    .tx_sop_i(tx_sop_i), .tx_eop_i(tx_eop_i), .tx_empty_i(tx_empty_i),
    .tx_data_i(tx_data_i), .tx_preamble_i(tx_preamble_i),
    .tx_raw_i(tx_raw_i), .sa_ins_en_i(sa_ins_en_i),
    .station_addr_i(station_addr_i), .out_valid_o(out_valid_o),
    .out_sop_o(out_sop_o), .out_eop_o(out_eop_o),
    .out_empty_o(out_empty_o), .out_data_o(out_data_o),
    .out_preamble_o(out_preamble_o), .out_ctrl_o(out_ctrl_o));

  txpp_client client_u (
    .clk_i(clk_i), .tx_valid_o(tx_valid_i), .tx_sop_o(tx_sop_i),
    .tx_eop_o(tx_eop_i), .tx_empty_o(tx_empty_i), .tx_data_o(tx_data_i),
    .tx_preamble_o(tx_preamble_i), .tx_raw_o(tx_raw_i));

  // Wider buses fed from the same client words, mid bus halves made distinct, wide bus four copies of the mid word
  assign d_m = {tx_data_i, ~tx_data_i};
  assign d_w = {4{d_m}};

  txpp_map #(.DW(128), .EW(4)) dut_m_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_i),
    .tx_sop_i(tx_sop_i), .tx_eop_i(tx_eop_i),
    .tx_empty_i({1'b0, tx_empty_i}), .tx_data_i(d_m),
    .tx_preamble_i(tx_preamble_i), .tx_raw_i(tx_raw_i),
    .sa_ins_en_i(sa_ins_en_i), .station_addr_i(station_addr_i),
    .out_valid_o(vld_m), .out_sop_o(sop_m), .out_eop_o(eop_m),
    .out_empty_o(out_empty_m), .out_data_o(out_data_m),
    .out_preamble_o(out_pre_m), .out_ctrl_o(ctl_m));

  txpp_map #(.DW(512), .EW(6)) dut_w_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .tx_valid_i(tx_valid_i),
    .tx_sop_i(tx_sop_i), .tx_eop_i(tx_eop_i),
    .tx_empty_i({3'h0, tx_empty_i}), .tx_data_i(d_w),
    .tx_preamble_i(tx_preamble_i), .tx_raw_i(tx_raw_i),
    .sa_ins_en_i(sa_ins_en_i), .station_addr_i(station_addr_i),
    .out_valid_o(vld_w), .out_sop_o(sop_w), .out_eop_o(eop_w),
    .out_empty_o(out_empty_w), .out_data_o(out_data_w),
    .out_preamble_o(out_pre_w), .out_ctrl_o(ctl_w));

  function automatic logic [63:0] map_w(input logic [63:0] d, input int n,
                                        input logic ins);
    map_w = d;
    if (n == 0) map_w[63:56] = TXPP_START_CHAR;
    if (n == 1 && ins) map_w[15:0] = station_addr_i[47:32];
    if (n == 2 && ins) map_w[63:32] = station_addr_i[31:0];
  endfunction : map_w

  function automatic logic [127:0] map_m(input logic [127:0] d,
                                         input logic s, input logic ins);
    map_m = d;
    if (s && ins) map_m[79:32] = station_addr_i;
  endfunction : map_m

  function automatic logic [511:0] map_x(input logic [511:0] d,
                                         input logic s, input logic ins);
    map_x = d;
    if (s) map_x[511:504] = TXPP_START_CHAR;
    if (s && ins) map_x[399:352] = station_addr_i;
  endfunction : map_x

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {e_vld, e_sop, e_eop, e_empty, e_data, e_pre} <= '0;
      idx <= 3;
      e_data_m <= '0;
      e_data_w <= '0;
    end else begin
      e_data_m <= map_m(d_m, tx_sop_i, sa_ins_en_i & ~tx_raw_i);
      e_data_w <= map_x(d_w, tx_sop_i, sa_ins_en_i & ~tx_raw_i);
      w = tx_sop_i ? 0 : idx;
      e_vld <= tx_valid_i;
      e_sop <= tx_valid_i & tx_sop_i;
      e_eop <= tx_valid_i & tx_eop_i;
      e_empty <= tx_empty_i;
      e_data <= map_w(tx_data_i, w, sa_ins_en_i & ~tx_raw_i);
      e_pre <= {(tx_sop_i ? TXPP_START_CHAR : tx_preamble_i[63:56]),
                tx_preamble_i[55:0]};
      if (tx_valid_i) idx <= (tx_eop_i || w > 1) ? 3 : w + 1;
    end
  end

  task check(input string nm, input logic [511:0] seen,
             input logic [511:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  always @(posedge clk_i) begin
    #2;
    check("valid", out_valid_o, e_vld);
    check("sop", out_sop_o, e_sop);
    check("eop", out_eop_o, e_eop);
    check("ctrl", out_ctrl_o, e_sop);
    check("empty", out_empty_o, e_empty);
    if (e_vld) check("data", out_data_o, e_data);
    if (e_sop) check("preamble", out_preamble_o, e_pre);
    check("valid_m", vld_m, e_vld);
    check("sop_m", sop_m, e_sop);
    check("eop_m", eop_m, e_eop);
    check("ctrl_m", ctl_m, 1'b0);
    check("empty_m", out_empty_m, {1'b0, e_empty});
    if (e_vld) check("data_m", out_data_m, e_data_m);
    if (e_sop) check("preamble_m", out_pre_m, e_pre);
    check("valid_w", vld_w, e_vld);
    check("sop_w", sop_w, e_sop);
    check("eop_w", eop_w, e_eop);
    check("ctrl_w", ctl_w, e_sop);
    check("empty_w", out_empty_w, {3'h0, e_empty});
    if (e_vld) check("data_w", out_data_w, e_data_w);
    if (e_sop) check("preamble_w", out_pre_w, e_pre);
    cyc++;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int n = 1; n < 5; n++) client_u.frame(n, 1'b0, 1'b1);
    client_u.idle();
    $display("test short back-to-back frames done");
    for (int k = 0; k < 60; k++) begin
      r = client_u.rnd();
      sa_ins_en_i = k[0];
      station_addr_i = r[47:0];
      client_u.frame(1 + r[50:48], k[1], r[63]);
      client_u.idle();
    end
    $display("test random frames done");
    rst_n_i = 1'b0;
    @(negedge clk_i);
    rst_n_i = 1'b1;
    client_u.frame(3, 1'b0, 1'b1);
    client_u.idle();
    repeat (2) @(negedge clk_i);
    $display("test reset recovery done");
    end_of_test();
  end
endmodule : txpp_map_tb
`default_nettype wire
